// file: hdl/gpab_ports.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module gpab_ports
(
    input  wire logic                         ref_clk,
    input  wire logic                         arst_n,
    input  wire logic [gpab_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [gpab_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [gpab_pkg::DATA_W-1:0]  avs_readdata,
    output logic                              avs_waitrequest,
    input  wire gpab_pkg::gpab_pins_t         pin_in,
    output gpab_pkg::gpab_pins_t              pin_out,
    output gpab_pkg::gpab_pins_t              pin_oe,
    output gpab_pkg::gpab_pins_t              pullup_on,
    output logic      [gpab_pkg::PA_W-1:0]    keypad_inputs,
    output logic      [gpab_pkg::PB_W-1:0]    analog_channel_inputs
);

    localparam int unsigned PA = gpab_pkg::PA_W;
    localparam int unsigned PB = gpab_pkg::PB_W;
    localparam int unsigned PC = gpab_pkg::PC_W;

    logic [PA-1:0] porta_latch;
    logic [PB-1:0] portb_latch;
    logic [PC-1:0] portc_latch;
    logic [PA-1:0] porta_direction;
    logic [PB-1:0] portb_direction;
    logic [PC-1:0] portc_direction;
    logic [PA-1:0] porta_pullup_enable;
    logic [PC-1:0] portc_pullup_enable;
    logic [PA-1:0] keypad_irq_enable_bits;
    logic [3:0]    analog_select;

    gpab_pkg::gpab_bus_state_t bus_state;
    gpab_pkg::gpab_bus_req_t   req;
    logic                      wr_take;
    logic [PB-1:0]             analog_force;
    logic [PB-1:0]             portb_eff_dir;
    logic [gpab_pkg::DATA_W-1:0] next_readdata;

    // Merge pin level and latch by direction
    function automatic logic [7:0] port_view(input logic [7:0] latch,
                                             input logic [7:0] pins,
                                             input logic [7:0] dir);
        port_view = (latch & dir) | (pins & ~dir);
    endfunction : port_view

    function automatic logic [PB-1:0] channel_mask(input logic [3:0] sel);
        logic [PB-1:0] m;
        m = '0;
        if (sel[gpab_pkg::ANA_EN_BIT] && (int'(sel[2:0]) < PB))
        begin
            m[sel[2:0]] = 1'b1;
        end
        channel_mask = m;
    endfunction : channel_mask

    assign req = '{index:      avs_address,
                   read:       avs_read,
                   write:      avs_write,
                   writedata:  avs_writedata,
                   byteenable: avs_byteenable};

    // Every access waits exactly one cycle, then completes
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_state <= gpab_pkg::GPAB_IDLE;
        end
        else
        begin
            unique case (bus_state)
                gpab_pkg::GPAB_IDLE:
                begin
                    if (req.read || req.write)
                    begin
                        bus_state <= gpab_pkg::GPAB_DONE;
                    end
                end
                gpab_pkg::GPAB_DONE:
                begin
                    bus_state <= gpab_pkg::GPAB_IDLE;
                end
                default:
                begin
                    bus_state <= gpab_pkg::GPAB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= !((bus_state == gpab_pkg::GPAB_IDLE)
                                 && (req.read || req.write));
        end
    end

    // Write commits on the edge where waitrequest is seen low, if byteenable[0] is set
    assign wr_take = req.write && !avs_waitrequest && req.byteenable[0];

    // Latches have no reset so their contents survive a reset
    always_ff @(posedge ref_clk)
    begin
        if (wr_take)
        begin
            unique case (req.index)
                gpab_pkg::IDX_PORT_A_DATA: porta_latch <= req.writedata[PA-1:0];
                gpab_pkg::IDX_PORT_B_DATA: portb_latch <= req.writedata[PB-1:0];
                gpab_pkg::IDX_PORT_C_DATA: portc_latch <= req.writedata[PC-1:0];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            porta_direction <= gpab_pkg::DIR_A_RESET;
            portb_direction <= gpab_pkg::DIR_B_RESET;
            portc_direction <= gpab_pkg::DIR_C_RESET;
        end
        else if (wr_take)
        begin
            if (req.index == gpab_pkg::IDX_PORT_A_DIR)
            begin
                porta_direction <= req.writedata[PA-1:0];
            end
            if (req.index == gpab_pkg::IDX_PORT_B_DIR)
            begin
                portb_direction <= req.writedata[PB-1:0];
            end
            if (req.index == gpab_pkg::IDX_PORT_C_DIR)
            begin
                portc_direction <= req.writedata[PC-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            porta_pullup_enable <= gpab_pkg::PULLUP_A_RESET;
            portc_pullup_enable <= gpab_pkg::PULLUP_C_RESET;
        end
        else if (wr_take)
        begin
            if (req.index == gpab_pkg::IDX_PORT_A_PULLUP)
            begin
                porta_pullup_enable <= req.writedata[PA-1:0];
            end
            if (req.index == gpab_pkg::IDX_PORT_C_PULLUP)
            begin
                portc_pullup_enable <= req.writedata[PC-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            keypad_irq_enable_bits <= gpab_pkg::KEYPAD_RESET;
            analog_select          <= gpab_pkg::ANA_RESET;
        end
        else if (wr_take)
        begin
            if (req.index == gpab_pkg::IDX_KEYPAD_CONTROL)
            begin
                keypad_irq_enable_bits <= req.writedata[PA-1:0];
            end
            if (req.index == gpab_pkg::IDX_ANALOG_SELECT)
            begin
                analog_select <= req.writedata[3:0];
            end
        end
    end

    assign analog_force  = channel_mask(analog_select);
    assign portb_eff_dir = portb_direction & ~analog_force;

    // Read data is taken from current state and pins
    always_comb
    begin
        next_readdata = gpab_pkg::UNMAPPED_READ;
        unique case (req.index)
            gpab_pkg::IDX_PORT_A_DATA:
                next_readdata[7:0] = port_view(8'(porta_latch), 8'(pin_in.a),
                                               8'(porta_direction));
            gpab_pkg::IDX_PORT_B_DATA:
                next_readdata[7:0] = port_view(8'(portb_latch), 8'(pin_in.b),
                                               8'(portb_direction));
            gpab_pkg::IDX_PORT_C_DATA:
                next_readdata[7:0] = port_view(8'(portc_latch), 8'(pin_in.c),
                                               8'(portc_direction));
            gpab_pkg::IDX_PORT_A_DIR:     next_readdata[7:0] = 8'(porta_direction);
            gpab_pkg::IDX_PORT_B_DIR:     next_readdata[7:0] = 8'(portb_direction);
            gpab_pkg::IDX_PORT_C_DIR:     next_readdata[7:0] = 8'(portc_direction);
            gpab_pkg::IDX_PORT_A_PULLUP:  next_readdata[7:0] = 8'(porta_pullup_enable);
            gpab_pkg::IDX_PORT_C_PULLUP:  next_readdata[7:0] = 8'(portc_pullup_enable);
            gpab_pkg::IDX_KEYPAD_CONTROL: next_readdata[7:0] = 8'(keypad_irq_enable_bits);
            gpab_pkg::IDX_ANALOG_SELECT:  next_readdata[7:0] = 8'(analog_select);
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avs_readdata <= gpab_pkg::UNMAPPED_READ;
        end
        else
        begin
            avs_readdata <= next_readdata;
        end
    end

    // Pin drivers registered: outputs follow settings one cycle later
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_out   <= '0;
            pin_oe    <= '0;
            pullup_on <= '0;
        end
        else
        begin
            pin_out.a   <= porta_latch & porta_direction;
            pin_out.b   <= portb_latch & portb_eff_dir;
            pin_out.c   <= portc_latch & portc_direction;
            pin_oe.a    <= porta_direction;
            pin_oe.b    <= portb_eff_dir;
            pin_oe.c    <= portc_direction;
            pullup_on.a <= porta_pullup_enable & ~porta_direction;
            pullup_on.b <= '0;
            pullup_on.c <= portc_pullup_enable & ~portc_direction;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            keypad_inputs         <= '0;
            analog_channel_inputs <= '0;
        end
        else
        begin
            keypad_inputs         <= keypad_irq_enable_bits & pin_in.a;
            analog_channel_inputs <= analog_force;
        end
    end

    property p_dir_reset;
        @(posedge ref_clk) $rose(arst_n) |-> (pin_oe == '0);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("oe not clear");

    property p_pullup_a;
        @(posedge ref_clk) disable iff (!arst_n)
        ##1 1'b1 |-> pullup_on.a == ($past(porta_pullup_enable) & ~$past(porta_direction));
    endproperty
    a_pullup_a: assert property (p_pullup_a) else $error("port A pullup wrong");

    property p_pullup_out_off;
        @(posedge ref_clk) disable iff (!arst_n)
        ((pin_oe.c & pullup_on.c) == '0) && ((pin_oe.a & pullup_on.a) == '0);
    endproperty
    a_pullup_out_off: assert property (p_pullup_out_off) else $error("pullup on output");

    property p_no_pullup_b;
        @(posedge ref_clk) disable iff (!arst_n) pullup_on.b == '0;
    endproperty
    a_no_pullup_b: assert property (p_no_pullup_b) else $error("port B pullup");

    property p_analog_override;
        @(posedge ref_clk) disable iff (!arst_n)
        ##1 1'b1 |-> (pin_oe.b & $past(analog_force)) == '0;
    endproperty
    a_analog_override: assert property (p_analog_override) else $error("analog pin driven");

    property p_drive_latch;
        @(posedge ref_clk) disable iff (!arst_n)
        ##1 1'b1 |-> (pin_out.c & pin_oe.c) == ($past(portc_latch) & $past(portc_direction));
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("port C drive wrong");

    property p_read_a;
        @(posedge ref_clk) disable iff (!arst_n)
        (req.read && req.index == gpab_pkg::IDX_PORT_A_DATA)
        |=> avs_readdata[7:0] == 8'(($past(porta_latch) & $past(porta_direction))
                                    | ($past(pin_in.a) & ~$past(porta_direction)));
    endproperty
    a_read_a: assert property (p_read_a) else $error("port A read wrong");

    property p_upper_zero;
        @(posedge ref_clk) disable iff (!arst_n) avs_readdata[31:8] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_one_wait;
        @(posedge ref_clk) disable iff (!arst_n)
        (avs_read && avs_waitrequest && bus_state == gpab_pkg::GPAB_IDLE)
        |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait timing wrong");

endmodule : gpab_ports

// file: shared/gpab_pkg.sv
package gpab_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PA_W   = 4;
    localparam int unsigned PB_W   = 6;
    localparam int unsigned PC_W   = 2;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_PORT_A_DATA    = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_PORT_B_DATA    = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_PORT_C_DATA    = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_PORT_A_DIR     = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_PORT_B_DIR     = 4'h5;
    localparam logic [ADDR_W-1:0] IDX_PORT_C_DIR     = 4'h6;
    localparam logic [ADDR_W-1:0] IDX_PORT_A_PULLUP  = 4'hd;
    localparam logic [ADDR_W-1:0] IDX_PORT_C_PULLUP  = 4'he;
    localparam logic [ADDR_W-1:0] IDX_KEYPAD_CONTROL = 4'h8;
    localparam logic [ADDR_W-1:0] IDX_ANALOG_SELECT  = 4'h9;

    localparam logic [PA_W-1:0] DIR_A_RESET    = 4'h0;
    localparam logic [PB_W-1:0] DIR_B_RESET    = 6'h00;
    localparam logic [PC_W-1:0] DIR_C_RESET    = 2'h0;
    localparam logic [PA_W-1:0] PULLUP_A_RESET = 4'h0;
    localparam logic [PC_W-1:0] PULLUP_C_RESET = 2'h0;
    localparam logic [PA_W-1:0] KEYPAD_RESET   = 4'h0;

    // Analog select: enable bit above a 3-bit channel number
    localparam int unsigned ANA_EN_BIT = 3;
    localparam logic [3:0]  ANA_RESET  = 4'h0;

    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    typedef struct packed {
        logic [PA_W-1:0] a;
        logic [PB_W-1:0] b;
        logic [PC_W-1:0] c;
    } gpab_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] index;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } gpab_bus_req_t;

    typedef enum logic [1:0] {
        GPAB_IDLE = 2'b01,
        GPAB_DONE = 2'b10
    } gpab_bus_state_t;

endpackage : gpab_pkg

// file: tb/gpab_pin_model.sv
`timescale 1ns/1ps
module gpab_pin_model
(
    input  wire logic                 ref_clk,
    input  wire gpab_pkg::gpab_pins_t pin_out,
    input  wire gpab_pkg::gpab_pins_t pin_oe,
    input  wire gpab_pkg::gpab_pins_t pullup_on,
    input  wire gpab_pkg::gpab_pins_t ext_en,
    input  wire gpab_pkg::gpab_pins_t ext_val,
    output gpab_pkg::gpab_pins_t      pin_in
);
    logic [11:0] last = 12'h000;
    logic [11:0] lvl;
    // A floating pin flips every cycle so no stale level passes for a real one
    always_comb
    begin
        for (int i = 0; i < 12; i++)
        begin
            if (pin_oe[i])
                lvl[i] = pin_out[i];
            else if (ext_en[i])
                lvl[i] = ext_val[i];
            else if (pullup_on[i])
                lvl[i] = 1'b1;
            else
                lvl[i] = ~last[i];
        end
    end
    always @(posedge ref_clk)
        last <= lvl;
    assign pin_in = gpab_pkg::gpab_pins_t'(lvl);
endmodule : gpab_pin_model

// file: tb/gpab_ports_tb_top.sv
`timescale 1ns/1ps
module gpab_ports_tb_top;
    logic                 ref_clk;
    logic                 arst_n;
    logic [3:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    gpab_pkg::gpab_pins_t pin_in;
    gpab_pkg::gpab_pins_t pin_out;
    gpab_pkg::gpab_pins_t pin_oe;
    gpab_pkg::gpab_pins_t pullup_on;
    gpab_pkg::gpab_pins_t ext_en;
    gpab_pkg::gpab_pins_t ext_val;
    logic [3:0]           keypad_inputs;
    logic [5:0]           analog_channel_inputs;
    int                   miscompares = 0;
    int                   compares = 0;
    int                   cycles = 0;
    logic [31:0]          rd;
    // Control registers that must come out of reset cleared
    logic [3:0] gpab_reset_idx [7] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hd, 4'he};

    gpab_ports i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_on(pullup_on), .keypad_inputs(keypad_inputs),
        .analog_channel_inputs(analog_channel_inputs));

    gpab_pin_model i_pins (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Entered just after a rising edge; holds the request until waitrequest is seen low
    task automatic bus_xfer(input logic wr, input logic [3:0] idx, input logic [31:0] data,
                            input logic [3:0] be);
        avs_address    <= idx;
        avs_writedata  <= data;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        @(posedge ref_clk);
        // No timeout of its own; a waitrequest stuck high is ended only by the bench timeout
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_xfer

    task automatic wr(input logic [3:0] idx, input logic [31:0] data);
        bus_xfer(1'b1, idx, data, 4'hf);
    endtask : wr

    task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
        bus_xfer(1'b0, idx, 32'h0000_0000, 4'hf);
        check(rd, exp);
    endtask : rd_chk

    // Pins follow registers an edge later; margin covers model and keypad stages
    task automatic settle();
        repeat (4) @(posedge ref_clk);
    endtask : settle

    initial
    begin
        arst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        ext_en = '0;
        ext_val = '0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (gpab_reset_idx[i])
            rd_chk(gpab_reset_idx[i], 32'h0000_0000);
        check({20'h0, pin_oe}, 32'h0000_0000);
        check({20'h0, pullup_on}, 32'h0000_0000);
        wr(4'h3, 32'h0000_00ff);
        rd_chk(4'h3, 32'h0000_0000);
        ext_en.a <= 4'hf;
        ext_val.a <= 4'ha;
        wr(4'h0, 32'h0000_00f5);
        settle();
        rd_chk(4'h0, 32'h0000_000a);
        ext_en.a <= 4'h0;
        wr(4'h4, 32'h0000_00ff);
        rd_chk(4'h4, 32'h0000_000f);
        settle();
        check({28'h0, pin_oe.a}, 32'h0000_000f);
        check({28'h0, pin_out.a}, 32'h0000_0005);
        rd_chk(4'h0, 32'h0000_0005);
        wr(4'h4, 32'h0000_0003);
        ext_en.a <= 4'hc;
        ext_val.a <= 4'h8;
        settle();
        rd_chk(4'h0, 32'h0000_0009);
        ext_en.a <= 4'h0;
        wr(4'hd, 32'h0000_00ff);
        rd_chk(4'hd, 32'h0000_000f);
        settle();
        check({28'h0, pullup_on.a}, 32'h0000_000c);
        rd_chk(4'h0, 32'h0000_000d);
        wr(4'h4, 32'h0000_0000);
        settle();
        check({28'h0, pullup_on.a}, 32'h0000_000f);
        wr(4'h8, 32'h0000_0006);
        ext_en.a <= 4'hf;
        ext_val.a <= 4'hf;
        settle();
        check({28'h0, keypad_inputs}, 32'h0000_0006);
        ext_val.a <= 4'h9;
        settle();
        check({28'h0, keypad_inputs}, 32'h0000_0000);
        ext_en.b <= 6'h3f;
        ext_val.b <= 6'h2a;
        wr(4'h1, 32'h0000_00d5);
        settle();
        rd_chk(4'h1, 32'h0000_002a);
        check({26'h0, pullup_on.b}, 32'h0000_0000);
        ext_en.b <= 6'h00;
        wr(4'h5, 32'h0000_00ff);
        rd_chk(4'h5, 32'h0000_003f);
        settle();
        check({26'h0, pin_oe.b}, 32'h0000_003f);
        rd_chk(4'h1, 32'h0000_0015);
        for (int ch = 0; ch < 6; ch++)
        begin
            wr(4'h9, 32'h0000_0008 | ch);
            settle();
            check({26'h0, analog_channel_inputs}, 32'h1 << ch);
            check({26'h0, pin_oe.b}, 32'h3f & ~(32'h1 << ch));
        end
        wr(4'h9, 32'h0000_0000);
        settle();
        check({26'h0, pin_oe.b}, 32'h0000_003f);
        wr(4'h9, 32'h0000_000e);
        settle();
        check({26'h0, analog_channel_inputs}, 32'h0000_0000);
        check({26'h0, pin_oe.b}, 32'h0000_003f);
        wr(4'h9, 32'h0000_0005);
        settle();
        check({26'h0, analog_channel_inputs}, 32'h0000_0000);
        rd_chk(4'h9, 32'h0000_0005);
        wr(4'he, 32'h0000_0003);
        settle();
        check({30'h0, pullup_on.c}, 32'h0000_0003);
        rd_chk(4'h2, 32'h0000_0003);
        wr(4'h2, 32'h0000_0001);
        settle();
        rd_chk(4'h2, 32'h0000_0003);
        wr(4'h6, 32'h0000_0002);
        settle();
        check({30'h0, pin_oe.c}, 32'h0000_0002);
        check({30'h0, pullup_on.c}, 32'h0000_0001);
        rd_chk(4'h2, 32'h0000_0001);
        bus_xfer(1'b1, 4'h6, 32'h0000_0003, 4'he);
        rd_chk(4'h6, 32'h0000_0002);
        ext_en.a <= 4'h0;
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rd_chk(4'h6, 32'h0000_0000);
        wr(4'h4, 32'h0000_000f);
        wr(4'h5, 32'h0000_003f);
        wr(4'h6, 32'h0000_0003);
        settle();
        rd_chk(4'h0, 32'h0000_0005);
        rd_chk(4'h1, 32'h0000_0015);
        rd_chk(4'h2, 32'h0000_0001);
        check({20'h0, pin_out}, 32'h0000_0555);
        end_of_test();
    end
endmodule : gpab_ports_tb_top
